// File: hdl/dcss_mode_decode.sv
// Purpose: maps a command-source mode code to its start/stop and direction routes
// Assumes: purely combinational, mode code from the control register or its write data
// Notes: valid low marks an unlisted code
`timescale 1ns/10ps
`default_nettype none
module dcss_mode_decode (
  input  wire logic [dcss_pkg::MODE_W-1:0] mode,  // mode code
  output var  dcss_pkg::dcss_route_t       route  // decoded routing
);

  always_comb begin
    route = '{ss: dcss_pkg::DCSS_SS_CON, dir: dcss_pkg::DCSS_DIR_CON, valid: 1'b1};
    case (mode)
      dcss_pkg::MODE_CONTACTS:    route = '{dcss_pkg::DCSS_SS_CON,    dcss_pkg::DCSS_DIR_CON,  1'b1};
      dcss_pkg::MODE_PROFILE:     route = '{dcss_pkg::DCSS_SS_PROF,   dcss_pkg::DCSS_DIR_PROF, 1'b1};
      dcss_pkg::MODE_REMOTE:      route = '{dcss_pkg::DCSS_SS_REM,    dcss_pkg::DCSS_DIR_REM,  1'b1};
      dcss_pkg::MODE_KP_DIRCON:   route = '{dcss_pkg::DCSS_SS_KP,     dcss_pkg::DCSS_DIR_CON,  1'b1};
      dcss_pkg::MODE_BOTH_DIRCON: route = '{dcss_pkg::DCSS_SS_ANY,    dcss_pkg::DCSS_DIR_CON,  1'b1};
      dcss_pkg::MODE_3W_CON:      route = '{dcss_pkg::DCSS_SS_3W_CON, dcss_pkg::DCSS_DIR_CON,  1'b1};
      dcss_pkg::MODE_KP_DIRKP:    route = '{dcss_pkg::DCSS_SS_KP,     dcss_pkg::DCSS_DIR_KP,   1'b1};
      dcss_pkg::MODE_BOTH_DIRKP:  route = '{dcss_pkg::DCSS_SS_ANY,    dcss_pkg::DCSS_DIR_KP,   1'b1};
      dcss_pkg::MODE_CW_CON:      route = '{dcss_pkg::DCSS_SS_CON,    dcss_pkg::DCSS_DIR_CW,   1'b1};
      dcss_pkg::MODE_CW_KP:       route = '{dcss_pkg::DCSS_SS_KP,     dcss_pkg::DCSS_DIR_CW,   1'b1};
      dcss_pkg::MODE_CW_BOTH:     route = '{dcss_pkg::DCSS_SS_ANY,    dcss_pkg::DCSS_DIR_CW,   1'b1};
      dcss_pkg::MODE_ACW_CON:     route = '{dcss_pkg::DCSS_SS_CON,    dcss_pkg::DCSS_DIR_ACW,  1'b1};
      dcss_pkg::MODE_ACW_KP:      route = '{dcss_pkg::DCSS_SS_KP,     dcss_pkg::DCSS_DIR_ACW,  1'b1};
      dcss_pkg::MODE_ACW_BOTH:    route = '{dcss_pkg::DCSS_SS_ANY,    dcss_pkg::DCSS_DIR_ACW,  1'b1};
      dcss_pkg::MODE_CON_DIRANY:  route = '{dcss_pkg::DCSS_SS_CON,    dcss_pkg::DCSS_DIR_ANY,  1'b1};
      dcss_pkg::MODE_ANY_ANY:     route = '{dcss_pkg::DCSS_SS_ANY,    dcss_pkg::DCSS_DIR_ANY,  1'b1};
      dcss_pkg::MODE_3W_ANY:      route = '{dcss_pkg::DCSS_SS_3W_ANY, dcss_pkg::DCSS_DIR_ANY,  1'b1};
      default:                    route.valid = 1'b0;
    endcase
  end

endmodule : dcss_mode_decode
`default_nettype wire

// File: hdl/dcss_pkg.sv
// Purpose: constants and carrier types for the drive command source selector
// Assumes: one clock, mode codes as plain unsigned numbers
// Notes: behaviour list below
// Behaviour
// RULE_01 - output stage enabled only while both safety enables are high; stage_en is registered and holds while clk_en is low
// RULE_02 - mode 0: start, stop, direction from digital contacts only
// RULE_03 - mode 1: start, stop, direction from fieldbus drive-profile machine
// RULE_04 - mode 2: start, stop, direction from protocol logic command bits
// RULE_05 - mode 3: start/stop from keypad, direction from contacts
// RULE_06 - mode 4: start/stop from keypad or contacts, direction from contacts
// RULE_07 - mode 14: start/stop from keypad or contacts, direction from keypad
// RULE_08 - mode 5: three-wire control, direction and hold from contacts
// RULE_09 - mode 13: start, stop, direction all from keypad
// RULE_10 - modes 20/23/24: clockwise only, start from contacts/keypad/either
// RULE_11 - modes 30/33/34: as 20/23/24 but anticlockwise only
// RULE_12 - mode 43: start/stop from contacts, direction from keypad or contacts
// RULE_13 - mode 44: start, stop, direction from keypad or contacts
// RULE_14 - mode 46: three-wire, direction and hold from contacts or keypad
// RULE_15 - mode change while running keeps running unless new source stops
// RULE_16 - unlisted mode code written is ignored, old mode stays
package dcss_pkg;

  localparam int MODE_W = 6;

  localparam logic [MODE_W-1:0] MODE_CONTACTS   = 6'h00;
  localparam logic [MODE_W-1:0] MODE_PROFILE    = 6'h01;
  localparam logic [MODE_W-1:0] MODE_REMOTE     = 6'h02;
  localparam logic [MODE_W-1:0] MODE_KP_DIRCON  = 6'h03;
  localparam logic [MODE_W-1:0] MODE_BOTH_DIRCON = 6'h04;
  localparam logic [MODE_W-1:0] MODE_3W_CON     = 6'h05;
  localparam logic [MODE_W-1:0] MODE_KP_DIRKP   = 6'h0d;
  localparam logic [MODE_W-1:0] MODE_BOTH_DIRKP = 6'h0e;
  localparam logic [MODE_W-1:0] MODE_CW_CON     = 6'h14;
  localparam logic [MODE_W-1:0] MODE_CW_KP      = 6'h17;
  localparam logic [MODE_W-1:0] MODE_CW_BOTH    = 6'h18;
  localparam logic [MODE_W-1:0] MODE_ACW_CON    = 6'h1e;
  localparam logic [MODE_W-1:0] MODE_ACW_KP     = 6'h21;
  localparam logic [MODE_W-1:0] MODE_ACW_BOTH   = 6'h22;
  localparam logic [MODE_W-1:0] MODE_CON_DIRANY = 6'h2b;
  localparam logic [MODE_W-1:0] MODE_ANY_ANY    = 6'h2c;
  localparam logic [MODE_W-1:0] MODE_3W_ANY     = 6'h2e;

  localparam logic [MODE_W-1:0] MODE_RESET      = 6'h00;

  // start/stop source select
  typedef enum logic [2:0] {
    DCSS_SS_CON, DCSS_SS_KP, DCSS_SS_ANY, DCSS_SS_PROF, DCSS_SS_REM,
    DCSS_SS_3W_CON, DCSS_SS_3W_ANY
  } dcss_ss_t;

  // direction source select
  typedef enum logic [2:0] {
    DCSS_DIR_CON, DCSS_DIR_KP, DCSS_DIR_ANY, DCSS_DIR_PROF, DCSS_DIR_REM,
    DCSS_DIR_CW, DCSS_DIR_ACW
  } dcss_dsel_t;

  // one command source: run request, stop request, direction request
  typedef struct packed {
    logic start_cw;
    logic start_acw;
    logic stop;
  } dcss_cmd_t;

  typedef struct packed {
    dcss_ss_t   ss;
    dcss_dsel_t dir;
    logic       valid;
  } dcss_route_t;

endpackage : dcss_pkg

// File: hdl/dcss_top.sv
// Purpose: selects start, stop and direction commands by command-source mode
// Assumes: all inputs synchronous to clk; sources give level commands
// Notes: run and direction held in flip-flops; outputs registered
`timescale 1ns/10ps
`default_nettype none
module dcss_top (
  input  wire logic                        clk,           // 250 MHz clock
  input  wire logic                        arst_n,        // async reset, low active
  input  wire logic                        clk_en,        // freezes all state when low
  input  wire logic [dcss_pkg::MODE_W-1:0] mode_wdata,    // new mode code
  input  wire logic                        mode_we,       // mode write strobe
  input  wire dcss_pkg::dcss_cmd_t         con_cmd,       // digital contacts
  input  wire logic                        con_hold,      // contact three-wire hold
  input  wire dcss_pkg::dcss_cmd_t         kp_cmd,        // keypad
  input  wire logic                        kp_hold,       // keypad three-wire hold
  input  wire dcss_pkg::dcss_cmd_t         prof_cmd,      // drive-profile machine
  input  wire dcss_pkg::dcss_cmd_t         rem_cmd,       // protocol logic bits
  input  wire logic                        safety_enable_in_a, // safety enable a
  input  wire logic                        safety_enable_in_b, // safety enable b
  output logic [dcss_pkg::MODE_W-1:0]      mode_q,        // active mode code
  output logic                             run,           // drive running
  output logic                             dir_acw,       // 1 anticlockwise
  output logic                             stage_en,      // output stage enable
  output logic                             mode_rejected  // last write ignored
);

  dcss_pkg::dcss_route_t route_cur;
  dcss_pkg::dcss_route_t route_new;

  logic [dcss_pkg::MODE_W-1:0] mode_reg, mode_next;
  logic run_reg, run_next, dir_reg, dir_next, en_reg, en_next, rej_reg, rej_next;
  logic start_cw, start_acw, stop_req, any_start;
  logic safe_ok;

  dcss_mode_decode u_dec_cur (
    .mode  (mode_reg),
    .route (route_cur)
  );

  dcss_mode_decode u_dec_new (
    .mode  (mode_wdata),
    .route (route_new)
  );

  // merges two sources: start from either, stop from either
  function automatic dcss_pkg::dcss_cmd_t merge(input dcss_pkg::dcss_cmd_t a,
                                                input dcss_pkg::dcss_cmd_t b);
    merge = a | b;
  endfunction : merge

  assign safe_ok = safety_enable_in_a & safety_enable_in_b;

  always_comb begin
    dcss_pkg::dcss_cmd_t ss_cmd;
    dcss_pkg::dcss_cmd_t dir_cmd;
    logic hold;
    ss_cmd  = '0;
    dir_cmd = '0;
    hold    = 1'b1;
    case (route_cur.ss)
      // RULE_02 contacts start
      dcss_pkg::DCSS_SS_CON:    ss_cmd = con_cmd;
      // RULE_09 keypad start
      dcss_pkg::DCSS_SS_KP:     ss_cmd = kp_cmd;
      // RULE_13 either source
      dcss_pkg::DCSS_SS_ANY:    ss_cmd = merge(con_cmd, kp_cmd);
      // RULE_03 profile start
      dcss_pkg::DCSS_SS_PROF:   ss_cmd = prof_cmd;
      // RULE_04 remote bits
      dcss_pkg::DCSS_SS_REM:    ss_cmd = rem_cmd;
      // RULE_08 three-wire contacts
      dcss_pkg::DCSS_SS_3W_CON: begin
        ss_cmd = con_cmd;
        hold   = con_hold;
      end
      // RULE_14 three-wire either
      dcss_pkg::DCSS_SS_3W_ANY: begin
        ss_cmd = merge(con_cmd, kp_cmd);
        hold   = con_hold | kp_hold;
      end
      default:                  ss_cmd = '0;
    endcase
    // three-wire: dropping hold acts as stop
    stop_req = ss_cmd.stop | ~hold;
    case (route_cur.dir)
      // RULE_05 direction contacts
      dcss_pkg::DCSS_DIR_CON:  dir_cmd = con_cmd;
      // RULE_07 direction keypad
      dcss_pkg::DCSS_DIR_KP:   dir_cmd = kp_cmd;
      // RULE_12 direction either
      dcss_pkg::DCSS_DIR_ANY:  dir_cmd = merge(con_cmd, kp_cmd);
      dcss_pkg::DCSS_DIR_PROF: dir_cmd = prof_cmd;
      dcss_pkg::DCSS_DIR_REM:  dir_cmd = rem_cmd;
      // RULE_10 clockwise fixed
      dcss_pkg::DCSS_DIR_CW:   dir_cmd = '{start_cw: 1'b1, start_acw: 1'b0, stop: 1'b0};
      // RULE_11 anticlockwise fixed
      dcss_pkg::DCSS_DIR_ACW:  dir_cmd = '{start_cw: 1'b0, start_acw: 1'b1, stop: 1'b0};
      default:                 dir_cmd = '0;
    endcase
    // RULE_06 start and direction split
    any_start = ss_cmd.start_cw | ss_cmd.start_acw;
    start_cw  = dir_cmd.start_cw & ~dir_cmd.start_acw;
    start_acw = dir_cmd.start_acw & ~dir_cmd.start_cw;
  end

  always_comb begin
    mode_next = mode_reg;
    rej_next  = rej_reg;
    run_next  = run_reg;
    dir_next  = dir_reg;
    if (mode_we) begin
      // RULE_16 unlisted code ignored
      if (route_new.valid) begin
        mode_next = mode_wdata;
        rej_next  = 1'b0;
      end else begin
        rej_next  = 1'b1;
      end
    end
    // RULE_15 run kept across change
    if (stop_req || !safe_ok) begin
      run_next = 1'b0;
    end else if (any_start && (start_cw || start_acw)) begin
      run_next = 1'b1;
      dir_next = start_acw;
    end else if (run_reg && (start_cw || start_acw)) begin
      dir_next = start_acw;
    end
    // RULE_01 both enables high
    en_next = safe_ok & run_next;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= dcss_pkg::MODE_RESET;
      rej_reg  <= 1'b0;
      run_reg  <= 1'b0;
      dir_reg  <= 1'b0;
      en_reg   <= 1'b0;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      rej_reg  <= rej_next;
      run_reg  <= run_next;
      dir_reg  <= dir_next;
      en_reg   <= en_next;
    end
  end

  assign mode_q        = mode_reg;
  assign run           = run_reg;
  assign dir_acw       = dir_reg;
  assign stage_en      = en_reg;
  assign mode_rejected = rej_reg;

  // RULE_01 enable needs both
  // frozen stage keeps its level, so look only after an enabled edge
  AST_SAFE_GATE: assert property (@(posedge clk) disable iff (!arst_n) // RULE_01
    $past(clk_en) && stage_en |-> $past(safety_enable_in_a) && $past(safety_enable_in_b))
    else $error("stage enabled without both safety enables");

  // RULE_01 enable a low stops
  AST_SAFE_DROP: assert property (@(posedge clk) disable iff (!arst_n) // RULE_01
    clk_en && !safety_enable_in_a |=> !stage_en && !run)
    else $error("safety enable low did not stop stage");

  // RULE_16 unlisted write ignored
  AST_BAD_MODE: assert property (@(posedge clk) disable iff (!arst_n) // RULE_16
    clk_en && mode_we && !route_new.valid |=> mode_q == $past(mode_q) && mode_rejected)
    else $error("unlisted mode was accepted");

  // RULE_16 listed write taken
  AST_GOOD_MODE: assert property (@(posedge clk) disable iff (!arst_n) // RULE_16
    clk_en && mode_we && route_new.valid |=> mode_q == $past(mode_wdata))
    else $error("listed mode not taken");

  // RULE_10 clockwise only
  AST_CW_ONLY: assert property (@(posedge clk) disable iff (!arst_n) // RULE_10
    clk_en && (mode_reg == dcss_pkg::MODE_CW_CON || mode_reg == dcss_pkg::MODE_CW_KP
    || mode_reg == dcss_pkg::MODE_CW_BOTH) && !mode_we && any_start && !stop_req && safe_ok
    |=> run && !dir_acw)
    else $error("clockwise-only mode ran anticlockwise");

  // RULE_11 anticlockwise only
  AST_ACW_ONLY: assert property (@(posedge clk) disable iff (!arst_n) // RULE_11
    clk_en && (mode_reg == dcss_pkg::MODE_ACW_CON || mode_reg == dcss_pkg::MODE_ACW_KP
    || mode_reg == dcss_pkg::MODE_ACW_BOTH) && any_start && !stop_req && safe_ok
    |=> run && dir_acw)
    else $error("anticlockwise-only mode ran clockwise");

  // RULE_02 contacts alone start
  AST_CON_ONLY: assert property (@(posedge clk) disable iff (!arst_n) // RULE_02
    clk_en && mode_reg == dcss_pkg::MODE_CONTACTS && !run && safe_ok
    && !(con_cmd.start_cw || con_cmd.start_acw) |=> !run)
    else $error("contacts mode started without contact start");

  // RULE_09 keypad alone starts
  AST_KP_ONLY: assert property (@(posedge clk) disable iff (!arst_n) // RULE_09
    clk_en && mode_reg == dcss_pkg::MODE_KP_DIRKP && !run
    && !(kp_cmd.start_cw || kp_cmd.start_acw) |=> !run)
    else $error("keypad mode started without keypad start");

  // RULE_15 run kept without stop
  AST_KEEP_RUN: assert property (@(posedge clk) disable iff (!arst_n) // RULE_15
    clk_en && run && safe_ok && !stop_req |=> run)
    else $error("run dropped without stop");

  // RULE_15 stop of source obeyed
  AST_STOP: assert property (@(posedge clk) disable iff (!arst_n) // RULE_15
    clk_en && stop_req |=> !run && !stage_en)
    else $error("stop not obeyed");

  // RULE_01 enable b low stops
  AST_SAFE_DROP_B: assert property (@(posedge clk) disable iff (!arst_n) // RULE_01
    clk_en && !safety_enable_in_b |=> !stage_en && !run)
    else $error("safety enable b low did not stop stage");

  // RULE_03 profile start and direction
  AST_PROF_START: assert property (@(posedge clk) disable iff (!arst_n) // RULE_03
    clk_en && mode_reg == dcss_pkg::MODE_PROFILE && safe_ok && !prof_cmd.stop
    && (prof_cmd.start_cw ^ prof_cmd.start_acw) |=>
    run && dir_acw == $past(prof_cmd.start_acw))
    else $error("profile start not obeyed");

  // RULE_03 other sources ignored
  AST_PROF_IGNORE: assert property (@(posedge clk) disable iff (!arst_n) // RULE_03
    clk_en && mode_reg == dcss_pkg::MODE_PROFILE && !run
    && !(prof_cmd.start_cw || prof_cmd.start_acw) |=> !run)
    else $error("profile mode started without profile start");

  // RULE_04 remote bits start
  AST_REM_START: assert property (@(posedge clk) disable iff (!arst_n) // RULE_04
    clk_en && mode_reg == dcss_pkg::MODE_REMOTE && safe_ok && !rem_cmd.stop
    && (rem_cmd.start_cw ^ rem_cmd.start_acw) |=>
    run && dir_acw == $past(rem_cmd.start_acw))
    else $error("remote start not obeyed");

  // RULE_04 remote stop
  AST_REM_STOP: assert property (@(posedge clk) disable iff (!arst_n) // RULE_04
    clk_en && mode_reg == dcss_pkg::MODE_REMOTE && rem_cmd.stop |=> !run)
    else $error("remote stop not obeyed");

  // RULE_05 keypad alone starts
  AST_KP_DIRCON: assert property (@(posedge clk) disable iff (!arst_n) // RULE_05
    clk_en && mode_reg == dcss_pkg::MODE_KP_DIRCON && !run
    && !(kp_cmd.start_cw || kp_cmd.start_acw) |=> !run)
    else $error("keypad start mode started without keypad");

  // RULE_05 direction from contacts
  AST_DIR_CON: assert property (@(posedge clk) disable iff (!arst_n) // RULE_05
    clk_en && mode_reg == dcss_pkg::MODE_KP_DIRCON && run && safe_ok && !kp_cmd.stop
    && (con_cmd.start_cw ^ con_cmd.start_acw) |=> dir_acw == $past(con_cmd.start_acw))
    else $error("direction not taken from contacts");

  // RULE_06 keypad start, contact direction
  AST_BOTH_DIRCON: assert property (@(posedge clk) disable iff (!arst_n) // RULE_06
    clk_en && mode_reg == dcss_pkg::MODE_BOTH_DIRCON && safe_ok && !con_cmd.stop
    && !kp_cmd.stop && (kp_cmd.start_cw || kp_cmd.start_acw)
    && (con_cmd.start_cw ^ con_cmd.start_acw) |=> run && dir_acw == $past(con_cmd.start_acw))
    else $error("keypad start with contact direction not obeyed");

  // RULE_07 contact start, keypad direction
  AST_BOTH_DIRKP: assert property (@(posedge clk) disable iff (!arst_n) // RULE_07
    clk_en && mode_reg == dcss_pkg::MODE_BOTH_DIRKP && safe_ok && !con_cmd.stop
    && !kp_cmd.stop && (con_cmd.start_cw || con_cmd.start_acw)
    && (kp_cmd.start_cw ^ kp_cmd.start_acw) |=> run && dir_acw == $past(kp_cmd.start_acw))
    else $error("contact start with keypad direction not obeyed");

  // RULE_08 hold low stops
  AST_3W_HOLD: assert property (@(posedge clk) disable iff (!arst_n) // RULE_08
    clk_en && mode_reg == dcss_pkg::MODE_3W_CON && !con_hold |=> !run)
    else $error("three-wire hold low did not stop");

  // RULE_09 keypad stop
  AST_KP_STOP: assert property (@(posedge clk) disable iff (!arst_n) // RULE_09
    clk_en && mode_reg == dcss_pkg::MODE_KP_DIRKP && kp_cmd.stop |=> !run)
    else $error("keypad stop not obeyed");

  // RULE_12 keypad start ignored
  AST_CON_DIRANY: assert property (@(posedge clk) disable iff (!arst_n) // RULE_12
    clk_en && mode_reg == dcss_pkg::MODE_CON_DIRANY && !run
    && !(con_cmd.start_cw || con_cmd.start_acw) |=> !run)
    else $error("contact start mode started without contacts");

  // RULE_13 keypad alone runs
  AST_ANY_ANY: assert property (@(posedge clk) disable iff (!arst_n) // RULE_13
    clk_en && mode_reg == dcss_pkg::MODE_ANY_ANY && safe_ok && !con_cmd.stop && !kp_cmd.stop
    && !con_cmd.start_cw && !con_cmd.start_acw && (kp_cmd.start_cw ^ kp_cmd.start_acw) |=>
    run && dir_acw == $past(kp_cmd.start_acw))
    else $error("keypad command in either-source mode not obeyed");

  // RULE_14 both holds low stop
  AST_3W_ANY_HOLD: assert property (@(posedge clk) disable iff (!arst_n) // RULE_14
    clk_en && mode_reg == dcss_pkg::MODE_3W_ANY && !con_hold && !kp_hold |=> !run)
    else $error("three-wire holds low did not stop");

  // RULE_14 keypad hold keeps run
  AST_3W_ANY_KEEP: assert property (@(posedge clk) disable iff (!arst_n) // RULE_14
    clk_en && mode_reg == dcss_pkg::MODE_3W_ANY && run && safe_ok && kp_hold
    && !con_cmd.stop && !kp_cmd.stop |=> run)
    else $error("keypad hold did not keep run");

  COV_START: cover property (@(posedge clk) disable iff (!arst_n) !run ##1 run);
  COV_MODE_SWITCH_RUN: cover property (@(posedge clk) disable iff (!arst_n)
    run && mode_we ##1 run);
  COV_REJECT: cover property (@(posedge clk) disable iff (!arst_n) !mode_rejected ##1 mode_rejected);
  COV_3W: cover property (@(posedge clk) disable iff (!arst_n)
    mode_reg == dcss_pkg::MODE_3W_ANY && run ##1 !run);
  COV_ACW_RUN: cover property (@(posedge clk) disable iff (!arst_n)
    mode_reg == dcss_pkg::MODE_ACW_BOTH && run && dir_acw);

endmodule : dcss_top
`default_nettype wire

// File: verif/dcss_src_model.sv
// Purpose: far-side command sources: contacts, keypad, profile machine, protocol bits
// Assumes: bench sets every level just after a rising edge
// Notes: levels pass straight through; sources have no latency of their own
`timescale 1ns/10ps
`default_nettype none
module dcss_src_model (
  input  wire dcss_pkg::dcss_cmd_t [3:0] req,      // contacts, keypad, profile, remote
  input  wire logic [1:0]               hold_req, // contact hold, keypad hold
  input  wire logic [1:0]               safe_req, // safety a, safety b
  output var  dcss_pkg::dcss_cmd_t      con_cmd,  // contact levels
  output var  dcss_pkg::dcss_cmd_t      kp_cmd,   // keypad levels
  output var  dcss_pkg::dcss_cmd_t      prof_cmd, // profile machine
  output var  dcss_pkg::dcss_cmd_t      rem_cmd,  // protocol bits
  output logic                          con_hold, // contact hold
  output logic                          kp_hold,  // keypad hold
  output logic                          safe_a,   // safety enable a
  output logic                          safe_b    // safety enable b
);
  assign con_cmd  = req[3];
  assign kp_cmd   = req[2];
  assign prof_cmd = req[1];
  assign rem_cmd  = req[0];
  assign con_hold = hold_req[0];
  assign kp_hold  = hold_req[1];
  // both enables wired
  // mostly driven high; bench drops them now and then to test the lock
  assign safe_a = safe_req[0];
  assign safe_b = safe_req[1];
endmodule : dcss_src_model
`default_nettype wire

// File: verif/tb.sv
// Purpose: random self-checking bench for the command source selector
// Assumes: mode writes come with idle commands, so either mode timing fits
// Notes: direction is checked only while running and not just after a write
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [5:0] CODES [17] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h0d,
    6'h0e, 6'h14, 6'h17, 6'h18, 6'h1e, 6'h21, 6'h22, 6'h2b, 6'h2c, 6'h2e};
  localparam logic [5:0] BAD [6] = '{6'h15, 6'h16, 6'h1f, 6'h20, 6'h3f, 6'h06};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b0;
  logic mode_we = 1'b0;
  logic skip = 1'b0;
  logic [5:0] mode_wdata = 6'h00;
  dcss_pkg::dcss_cmd_t [3:0] req = '0;
  logic [1:0] hold_req = 2'b11;
  logic [1:0] safe_req = 2'b11;
  dcss_pkg::dcss_cmd_t con_cmd, kp_cmd, prof_cmd, rem_cmd;
  logic con_hold, kp_hold, safe_a, safe_b;
  logic [5:0] mode_q;
  logic [5:0] m_mode = 6'h00;
  logic run, dir_acw, stage_en, mode_rejected;
  logic m_run = 1'b0;
  logic m_dir = 1'b0;
  logic m_rej = 1'b0;
  int err_total = 0;
  int checks_done = 0;

  always #2 clk = ~clk;

  dcss_src_model i_dcss_src_model (.req(req), .hold_req(hold_req), .safe_req(safe_req),
    .con_cmd(con_cmd), .kp_cmd(kp_cmd), .prof_cmd(prof_cmd), .rem_cmd(rem_cmd),
    .con_hold(con_hold), .kp_hold(kp_hold), .safe_a(safe_a), .safe_b(safe_b));
  dcss_top i_dcss_top (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .mode_wdata(mode_wdata),
    .mode_we(mode_we), .con_cmd(con_cmd), .con_hold(con_hold), .kp_cmd(kp_cmd),
    .kp_hold(kp_hold), .prof_cmd(prof_cmd), .rem_cmd(rem_cmd), .safety_enable_in_a(safe_a),
    .safety_enable_in_b(safe_b), .mode_q(mode_q), .run(run), .dir_acw(dir_acw),
    .stage_en(stage_en), .mode_rejected(mode_rejected));

  function automatic logic listed(input logic [5:0] m);
    foreach (CODES[i]) if (CODES[i] === m) return 1'b1;
    return 1'b0;
  endfunction : listed

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // expected state from the levels about to be sampled
  task automatic model_step();
    dcss_pkg::dcss_cmd_t c, k, ss, dr;
    logic [1:0] fx;
    logic hl, st, sp, ok, nd, nr;
    c = req[3];
    k = req[2];
    fx = 2'b00;
    hl = 1'b0;
    case (m_mode)
      6'd1: begin ss = req[1]; dr = req[1]; end
      6'd2: begin ss = req[0]; dr = req[0]; end
      6'd3: begin ss = k; dr = c; end
      6'd4: begin ss = c | k; dr = c; end
      6'd5: begin ss = c; dr = c; hl = !hold_req[0]; end
      6'd13: begin ss = k; dr = k; end
      6'd14: begin ss = c | k; dr = k; end
      6'd20, 6'd30: begin ss = c; dr = c; fx = {1'b1, m_mode >= 6'd30}; end
      6'd23, 6'd33: begin ss = k; dr = k; fx = {1'b1, m_mode >= 6'd30}; end
      6'd24, 6'd34: begin ss = c | k; dr = c; fx = {1'b1, m_mode >= 6'd30}; end
      6'd43: begin ss = c; dr = c | k; end
      6'd44: begin ss = c | k; dr = c | k; end
      6'd46: begin ss = c | k; dr = c | k; hl = !(hold_req[0] | hold_req[1]); end
      default: begin ss = c; dr = c; end
    endcase
    st = ss.start_cw | ss.start_acw;
    sp = ss.stop | hl;
    ok = fx[1] | (dr.start_cw ^ dr.start_acw);
    nd = fx[1] ? fx[0] : dr.start_acw;
    nr = (&safe_req) & !sp & (m_run | (st & ok));
    if (!clk_en)
      return;
    if (nr && ok)
      m_dir = nd;
    m_run = nr;
    if (mode_we && listed(mode_wdata)) begin
      m_mode = mode_wdata;
      m_rej = 1'b0;
    end else if (mode_we)
      m_rej = 1'b1;
  endtask : model_step

  task automatic cycle(input logic wr, input logic [5:0] code);
    @(posedge clk);
    #1;
    chk({2'b00, mode_q}, {2'b00, m_mode});
    chk({7'b0, mode_rejected}, {7'b0, m_rej});
    chk({6'b0, run, stage_en}, {6'b0, m_run, m_run});
    if (m_run && !skip) chk({7'b0, dir_acw}, {7'b0, m_dir});
    skip = wr;
    mode_we = wr;
    mode_wdata = code;
    clk_en = ($urandom % 8) != 0;
    safe_req = ($urandom % 32 == 0) ? 2'($urandom) : 2'b11;
    hold_req = ($urandom % 8 == 0) ? 2'($urandom) : 2'b11;
    foreach (req[i]) req[i] = {2'($urandom), 1'($urandom % 16 == 0)};
    if (wr) begin
      req = '0;
      hold_req = 2'b11;
    end
    model_step();
  endtask : cycle

  initial begin
    #40000;
    err_total++;
    final_report();
  end

  initial begin
    void'($urandom(69470));
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'b1;
    // every listed code, each followed by random traffic
    foreach (CODES[i]) begin
      repeat (3) cycle(1'b1, CODES[i]);
      repeat (60) cycle(1'b0, 6'h00);
      $display("mode %0d done", CODES[i]);
    end
    // unlisted codes between listed ones
    foreach (BAD[i]) begin
      cycle(1'b1, BAD[i]);
      repeat (8) cycle(1'b0, 6'h00);
      cycle(1'b1, CODES[i]);
      $display("unlisted code %0d done", BAD[i]);
    end
    final_report();
  end
endmodule : tb
`default_nettype wire
